// ---- rtl/tbm_pkg.sv ----
/*
  Constants, register map and carrier types of the two-wire bus master.
  Assumes a 10 MHz core clock; all counts below are derived from that period.
*/
package tbm_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned RATE_SLOW_KBPS = 100;
  localparam int unsigned RATE_MID_KBPS = 250;
  localparam int unsigned RATE_FAST_KBPS = 400;
  // Quarter bit periods in core cycles, rounded down so no quarter runs long
  localparam logic [4:0] QTR_SLOW = 5'(1_000_000 / (RATE_SLOW_KBPS * 4 * CLK_PERIOD_NS));
  localparam logic [4:0] QTR_MID = 5'(1_000_000 / (RATE_MID_KBPS * 4 * CLK_PERIOD_NS));
  localparam logic [4:0] QTR_FAST = 5'(1_000_000 / (RATE_FAST_KBPS * 4 * CLK_PERIOD_NS));

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [11:0] OFS_BEGIN_READ = 12'h000;
  localparam logic [11:0] OFS_BEGIN_WRITE = 12'h008;
  localparam logic [11:0] OFS_STOP = 12'h014;
  localparam logic [11:0] OFS_SUSPEND = 12'h01c;
  localparam logic [11:0] OFS_RESUME = 12'h020;
  localparam logic [11:0] OFS_EV_STOPPED = 12'h104;
  localparam logic [11:0] OFS_EV_ERROR = 12'h124;
  localparam logic [11:0] OFS_EV_SUSPENDED = 12'h148;
  localparam logic [11:0] OFS_EV_READ_BEGAN = 12'h14c;
  localparam logic [11:0] OFS_EV_WRITE_BEGAN = 12'h150;
  localparam logic [11:0] OFS_EV_FINAL_READ = 12'h15c;
  localparam logic [11:0] OFS_EV_FINAL_WRITE = 12'h160;
  localparam logic [11:0] OFS_SHORTCUTS = 12'h200;
  localparam logic [11:0] OFS_ENABLE = 12'h500;
  localparam logic [11:0] OFS_BUS_RATE = 12'h524;
  localparam logic [11:0] OFS_READ_PTR = 12'h534;
  localparam logic [11:0] OFS_READ_LEN = 12'h538;
  localparam logic [11:0] OFS_READ_AMOUNT = 12'h53c;
  localparam logic [11:0] OFS_WRITE_PTR = 12'h544;
  localparam logic [11:0] OFS_WRITE_LEN = 12'h548;
  localparam logic [11:0] OFS_WRITE_AMOUNT = 12'h54c;
  localparam logic [11:0] OFS_SLAVE_ADDR = 12'h588;

  // ************************************************************
  // Fields, codes and reset values
  // ************************************************************
  localparam int unsigned SHORT_FINAL_WRITE_STOP = 0;
  localparam int unsigned SHORT_FINAL_READ_STOP = 1;
  localparam logic [1:0] RATE_CODE_100 = 2'h0;
  localparam logic [1:0] RATE_CODE_250 = 2'h1;
  localparam logic [1:0] RATE_CODE_400 = 2'h2;
  localparam logic [1:0] RATE_RST = 2'h0;
  localparam logic [1:0] SHORTS_RST = 2'h0;
  localparam logic [6:0] SLAVE_ADDR_RST = 7'h00;
  localparam logic [31:0] PTR_RST = 32'h0000_0000;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic begin_read_task;
    logic begin_write_task;
    logic stop_task;
    logic suspend_task;
    logic resume_task;
  } tbm_tasks_s;

  typedef struct packed {
    logic stopped_event;
    logic error_event;
    logic suspended_event;
    logic read_began_event;
    logic write_began_event;
    logic final_read_byte_event;
    logic final_write_byte_event;
  } tbm_events_s;

  // Event register offsets, in the bit order of tbm_events_s (bit 6 first)
  localparam logic [6:0][11:0] EV_OFS = {OFS_EV_STOPPED, OFS_EV_ERROR, OFS_EV_SUSPENDED,
    OFS_EV_READ_BEGAN, OFS_EV_WRITE_BEGAN, OFS_EV_FINAL_READ, OFS_EV_FINAL_WRITE};

endpackage

// ---- rtl/tbm_two_wire_bus_master.sv ----
/*
  Single-master two-wire bus controller with byte DMA reader and writer.
  Assumes an AHB-Lite master on the register port, a byte-wide memory port
  answering req with a one-cycle ack, and open-drain pins resolved outside.
*/
// Function
// - Write start: start, address, direction 0
// - Read start: start, address, direction 1
// - Write bytes fetched from pointer, ack sampled
// - Read bytes stored; ack all, nack final
// - Sampled not-acknowledge raises the error event
// - Never stops alone; stop task required
// - Stop completes, then stopped event, DMA done
// - Final write event when last byte begins
// - Final read event after previous acknowledge
// - Shortcut from final write to stop
// - Suspend holds clock low, raises suspended
// - Suspend at byte boundary, only when busy
// - Stop ignored while suspended
// - Pointers and lengths are double-buffered
// - Bus rates 100, 250, 400 kbit/s
// - Wait while slave stretches the clock
// - Sole master, no arbitration
// - Disable leaves registers unchanged
// - Slave address from dedicated register
module tbm_two_wire_bus_master
  import tbm_pkg::*;
#(
  parameter int unsigned CNT_W = 16
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire tbm_tasks_s fabric_tasks,
  output tbm_events_s events_out,
  output logic dma_req,
  output logic dma_we,
  output logic [31:0] dma_addr,
  output logic [7:0] dma_wdata,
  input wire logic [7:0] dma_rdata,
  input wire logic dma_ack,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oen,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oen
);

  generate
    if (CNT_W < 1 || CNT_W > 32)
    begin : g_bad_cnt
      $error("CNT_W must lie in 1..32");
    end
  endgenerate

  // ************************************************************
  // Declarations
  // ************************************************************
  typedef enum logic [3:0] {ST_IDLE, ST_START, ST_BIT, ST_FETCH, ST_STORE, ST_NEXT, ST_HOLD, ST_SUSP,
    ST_STOP} tbm_state_e;

  logic ahb_act_r, ahb_wr_r, hready_r, hresp_r, wr_en;
  logic [11:0] ahb_adr_r;
  logic [31:0] hrdata_r, rd_mux;
  logic enable_r;
  logic [1:0] rate_r, shorts_r;
  logic [6:0] slave_addr_r;
  logic [31:0] rd_ptr_sh_r, wr_ptr_sh_r, ptr_r;
  logic [CNT_W-1:0] rd_len_sh_r, wr_len_sh_r, len_r, cnt_r, rd_amt_r, wr_amt_r, last_idx;
  logic [6:0] ev_sticky_r, ev_vec;
  tbm_tasks_s reg_tasks, tasks;
  tbm_events_s ev_r;
  tbm_state_e st_r;
  logic [1:0] ph_r;
  logic [4:0] qcnt_r, qlim;
  logic [3:0] bitn_r;
  logic [8:0] sh_r;
  logic is_rd_r, in_adr_r, stop_pend_r, susp_pend_r;
  logic dma_req_r, dma_we_r;
  logic [31:0] dma_addr_r;
  logic [7:0] dma_wdata_r;
  logic scl_m_r, scl_s_r, sda_m_r, sda_s_r;
  logic scl_oen_r, sda_oen_r, scl_oen_nxt, sda_oen_nxt, pin_lvl_r;
  logic timed, stall, q_end, start_go;

  assign hreadyout = hready_r;
  assign hrdata = hrdata_r;
  assign hresp = hresp_r;
  assign events_out = ev_r;
  assign dma_req = dma_req_r;
  assign dma_we = dma_we_r;
  assign dma_addr = dma_addr_r;
  assign dma_wdata = dma_wdata_r;
  assign scl_out = pin_lvl_r;
  assign sda_out = pin_lvl_r;
  assign scl_oen = scl_oen_r;
  assign sda_oen = sda_oen_r;

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  // Address phase capture; reads take one wait state so hrdata comes from a flop
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ahb_act_r <= 1'b0;
      ahb_wr_r <= 1'b0;
      ahb_adr_r <= 12'h000;
      hready_r <= 1'b1;
      hresp_r <= 1'b0;
      hrdata_r <= 32'h0000_0000;
    end
    else
    begin
      ahb_act_r <= hsel && hready && htrans[1];
      if (hsel && hready && htrans[1])
      begin
        ahb_adr_r <= haddr[11:0];
        ahb_wr_r <= hwrite;
      end
      hready_r <= !(hsel && hready && htrans[1] && !hwrite);
      if (ahb_act_r && !ahb_wr_r)
        hrdata_r <= rd_mux;
    end
  end

  assign wr_en = ahb_act_r && ahb_wr_r;

  // Task registers: writing 1 gives a one-cycle trigger, merged with the fabric
  always_comb
  begin
    reg_tasks.begin_read_task = wr_en && ahb_adr_r == OFS_BEGIN_READ && hwdata[0];
    reg_tasks.begin_write_task = wr_en && ahb_adr_r == OFS_BEGIN_WRITE && hwdata[0];
    reg_tasks.stop_task = wr_en && ahb_adr_r == OFS_STOP && hwdata[0];
    reg_tasks.suspend_task = wr_en && ahb_adr_r == OFS_SUSPEND && hwdata[0];
    reg_tasks.resume_task = wr_en && ahb_adr_r == OFS_RESUME && hwdata[0];
    tasks = reg_tasks | fabric_tasks;
  end

  // Configuration; shadows feed the engine only when a start is taken
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      enable_r <= 1'b0;
      rate_r <= RATE_RST;
      shorts_r <= SHORTS_RST;
      slave_addr_r <= SLAVE_ADDR_RST;
      rd_ptr_sh_r <= PTR_RST;
      wr_ptr_sh_r <= PTR_RST;
      rd_len_sh_r <= '0;
      wr_len_sh_r <= '0;
    end
    else if (wr_en)
    begin
      // Clearing enable touches nothing else, so settings survive a disable
      unique case (ahb_adr_r)
        OFS_ENABLE: enable_r <= hwdata[0];
        OFS_BUS_RATE: rate_r <= hwdata[1:0];
        OFS_SHORTCUTS: shorts_r <= hwdata[1:0];
        OFS_SLAVE_ADDR: slave_addr_r <= hwdata[6:0];
        OFS_READ_PTR: rd_ptr_sh_r <= hwdata;
        OFS_WRITE_PTR: wr_ptr_sh_r <= hwdata;
        OFS_READ_LEN: rd_len_sh_r <= hwdata[CNT_W-1:0];
        OFS_WRITE_LEN: wr_len_sh_r <= hwdata[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky event bits: hardware set wins over a software write of 0
  assign ev_vec = ev_r;
  generate
    for (genvar i = 0; i < 7; i++)
    begin : g_ev
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
          ev_sticky_r[i] <= 1'b0;
        else if (ev_vec[i])
          ev_sticky_r[i] <= 1'b1;
        else if (wr_en && ahb_adr_r == EV_OFS[i] && !hwdata[0])
          ev_sticky_r[i] <= 1'b0;
      end
    end
  endgenerate

  // Read multiplexer; unmapped and task offsets read as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (ahb_adr_r)
      OFS_ENABLE: rd_mux = {31'h0, enable_r};
      OFS_BUS_RATE: rd_mux = {30'h0, rate_r};
      OFS_SHORTCUTS: rd_mux = {30'h0, shorts_r};
      OFS_SLAVE_ADDR: rd_mux = {25'h0, slave_addr_r};
      OFS_READ_PTR: rd_mux = rd_ptr_sh_r;
      OFS_WRITE_PTR: rd_mux = wr_ptr_sh_r;
      OFS_READ_LEN: rd_mux = 32'(rd_len_sh_r);
      OFS_WRITE_LEN: rd_mux = 32'(wr_len_sh_r);
      OFS_READ_AMOUNT: rd_mux = 32'(rd_amt_r);
      OFS_WRITE_AMOUNT: rd_mux = 32'(wr_amt_r);
      default: ;
    endcase
    for (int i = 0; i < 7; i++)
      if (ahb_adr_r == EV_OFS[i])
        rd_mux = {31'h0, ev_sticky_r[i]};
  end

  // ************************************************************
  // Pin side
  // ************************************************************
  // Two-stage synchronisers; only the second stage is used
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      pin_lvl_r <= 1'b0;
    end
    else
    begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      pin_lvl_r <= 1'b0;
    end
  end

  // Quarter-bit timer; while the clock line is released but still low the slave is stretching
  always_comb
  begin
    unique case (rate_r)
      RATE_CODE_250: qlim = QTR_MID;
      RATE_CODE_400: qlim = QTR_FAST;
      default: qlim = QTR_SLOW;
    endcase
    timed = st_r == ST_START || st_r == ST_BIT || st_r == ST_STOP;
    stall = timed && ph_r == 2'd2 && !scl_s_r;
    q_end = timed && qcnt_r == 5'h00 && !stall;
    start_go = enable_r && (tasks.begin_read_task || tasks.begin_write_task)
      && (st_r == ST_IDLE || st_r == ST_HOLD);
    last_idx = len_r - CNT_W'(1);
  end

  // Line drive: SDA only changes while SCL is held low, except for start and stop edges
  always_comb
  begin
    scl_oen_nxt = 1'b0;
    sda_oen_nxt = sda_oen_r;
    unique case (st_r)
      ST_IDLE:
      begin
        scl_oen_nxt = 1'b1;
        sda_oen_nxt = 1'b1;
      end
      ST_START:
      begin
        scl_oen_nxt = ph_r[1] ? 1'b1 : scl_oen_r;
        if (ph_r == 2'd1 || ph_r == 2'd2)
          sda_oen_nxt = 1'b1;
        else if (ph_r == 2'd3)
          sda_oen_nxt = 1'b0;
      end
      ST_BIT:
      begin
        scl_oen_nxt = ph_r[1];
        // Data moves only in quarter 1: the shift at the end of quarter 2 must not reach the line
        if (ph_r == 2'd1)
          sda_oen_nxt = sh_r[8];
      end
      ST_STOP:
      begin
        scl_oen_nxt = ph_r[1];
        if (ph_r == 2'd1 || ph_r == 2'd2)
          sda_oen_nxt = 1'b0;
        else if (ph_r == 2'd3)
          sda_oen_nxt = 1'b1;
      end
      ST_SUSP: scl_oen_nxt = 1'b0;
      default: scl_oen_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_oen_r <= 1'b1;
      sda_oen_r <= 1'b1;
    end
    else
    begin
      scl_oen_r <= scl_oen_nxt;
      sda_oen_r <= sda_oen_nxt;
    end
  end

  // ************************************************************
  // Transfer sequencer
  // ************************************************************
  // Lost arbitration is never checked: this is the only master on the bus
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= ST_IDLE;
      ph_r <= 2'd0;
      qcnt_r <= 5'h00;
      bitn_r <= 4'h0;
      sh_r <= 9'h1ff;
      is_rd_r <= 1'b0;
      in_adr_r <= 1'b0;
      ptr_r <= PTR_RST;
      len_r <= '0;
      cnt_r <= '0;
      rd_amt_r <= '0;
      wr_amt_r <= '0;
      stop_pend_r <= 1'b0;
      susp_pend_r <= 1'b0;
      ev_r <= '0;
      dma_req_r <= 1'b0;
      dma_we_r <= 1'b0;
      dma_addr_r <= PTR_RST;
      dma_wdata_r <= 8'h00;
    end
    else
    begin
      ev_r <= '0;
      if (!timed || (q_end && qcnt_r == 5'h00))
        qcnt_r <= qlim - 5'h01;
      else if (!stall)
        qcnt_r <= qcnt_r - 5'h01;
      if (q_end)
        ph_r <= ph_r + 2'd1;
      // Stop is latched while busy, dropped while suspended
      if (tasks.stop_task && st_r != ST_IDLE && st_r != ST_SUSP)
        stop_pend_r <= 1'b1;
      // Suspend only counts during a transfer and waits for the byte boundary
      if (tasks.suspend_task && st_r != ST_IDLE && st_r != ST_SUSP && st_r != ST_STOP)
        susp_pend_r <= 1'b1;
      if (start_go)
      begin
        // Shadows copied here, so software may rewrite them after the began event
        is_rd_r <= tasks.begin_read_task;
        ptr_r <= tasks.begin_read_task ? rd_ptr_sh_r : wr_ptr_sh_r;
        len_r <= tasks.begin_read_task ? rd_len_sh_r : wr_len_sh_r;
        cnt_r <= '0;
        if (tasks.begin_read_task)
          rd_amt_r <= '0;
        else
          wr_amt_r <= '0;
        ev_r.read_began_event <= tasks.begin_read_task;
        ev_r.write_began_event <= !tasks.begin_read_task;
        ph_r <= 2'd0;
        st_r <= ST_START;
      end
      else
      begin
        unique case (st_r)
          ST_IDLE:
            if (tasks.stop_task)
              ev_r.stopped_event <= 1'b1;
          ST_START:
            if (q_end && ph_r == 2'd3)
            begin
              sh_r <= {slave_addr_r, is_rd_r, 1'b1};
              in_adr_r <= 1'b1;
              bitn_r <= 4'h0;
              st_r <= ST_BIT;
            end
          ST_BIT:
          begin
            if (q_end && ph_r == 2'd2)
              sh_r <= {sh_r[7:0], sda_s_r};
            if (q_end && ph_r == 2'd3)
            begin
              if (bitn_r != 4'h8)
                bitn_r <= bitn_r + 4'h1;
              else
              begin
                // Slave ack bit after address or written byte: 1 is not-acknowledge
                if (sh_r[0] && (in_adr_r || !is_rd_r))
                  ev_r.error_event <= 1'b1;
                if (!in_adr_r && !is_rd_r)
                begin
                  cnt_r <= cnt_r + CNT_W'(1);
                  wr_amt_r <= cnt_r + CNT_W'(1);
                end
                in_adr_r <= 1'b0;
                st_r <= (!in_adr_r && is_rd_r) ? ST_STORE : ST_NEXT;
              end
            end
          end
          ST_FETCH:
            if (dma_req_r && dma_ack)
            begin
              dma_req_r <= 1'b0;
              sh_r <= {dma_rdata, 1'b1};
              bitn_r <= 4'h0;
              ph_r <= 2'd0;
              st_r <= ST_BIT;
              if (cnt_r == last_idx)
              begin
                ev_r.final_write_byte_event <= 1'b1;
                if (shorts_r[SHORT_FINAL_WRITE_STOP])
                  stop_pend_r <= 1'b1;
              end
            end
            else if (!dma_req_r)
            begin
              dma_req_r <= 1'b1;
              dma_we_r <= 1'b0;
              dma_addr_r <= ptr_r + 32'(cnt_r);
            end
          ST_STORE:
            if (dma_req_r && dma_ack)
            begin
              dma_req_r <= 1'b0;
              cnt_r <= cnt_r + CNT_W'(1);
              rd_amt_r <= cnt_r + CNT_W'(1);
              st_r <= ST_NEXT;
            end
            else if (!dma_req_r)
            begin
              dma_req_r <= 1'b1;
              dma_we_r <= 1'b1;
              dma_addr_r <= ptr_r + 32'(cnt_r);
              dma_wdata_r <= sh_r[8:1];
            end
          ST_NEXT:
          begin
            ph_r <= 2'd0;
            bitn_r <= 4'h0;
            if (stop_pend_r)
              st_r <= ST_STOP;
            else if (susp_pend_r)
            begin
              susp_pend_r <= 1'b0;
              ev_r.suspended_event <= 1'b1;
              st_r <= ST_SUSP;
            end
            else if (cnt_r < len_r && !is_rd_r)
              st_r <= ST_FETCH;
            else if (cnt_r < len_r)
            begin
              // Ack low for all but the last byte, which gets a released (nack) bit
              sh_r <= {8'hff, cnt_r == last_idx};
              st_r <= ST_BIT;
              if (cnt_r == last_idx)
              begin
                ev_r.final_read_byte_event <= 1'b1;
                if (shorts_r[SHORT_FINAL_READ_STOP])
                  stop_pend_r <= 1'b1;
              end
            end
            else
              st_r <= ST_HOLD;
          end
          ST_HOLD:
            if (stop_pend_r || tasks.stop_task)
            begin
              ph_r <= 2'd0;
              st_r <= ST_STOP;
            end
            else if (susp_pend_r || tasks.suspend_task)
            begin
              susp_pend_r <= 1'b0;
              ev_r.suspended_event <= 1'b1;
              st_r <= ST_SUSP;
            end
          ST_SUSP:
            if (tasks.resume_task)
              st_r <= ST_NEXT;
          ST_STOP:
            if (q_end && ph_r == 2'd3)
            begin
              // All memory traffic finished before the stop began
              stop_pend_r <= 1'b0;
              susp_pend_r <= 1'b0;
              ev_r.stopped_event <= 1'b1;
              st_r <= ST_IDLE;
            end
        endcase
      end
    end
  end

endmodule

// ---- testbench/tbm_asserts.sv ----
/*
  Port checks of the two-wire bus master.
  Assumes hready is hreadyout and the bench memory acks DMA.
*/
module tbm_checker
  import tbm_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire tbm_events_s events_out,
  input wire logic dma_req,
  input wire logic dma_we,
  input wire logic [31:0] dma_addr,
  input wire logic dma_ack,
  input wire logic scl_oen,
  input wire logic sda_oen
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Line events: data moves while the clock line is released
  sequence start_s;
    $fell(sda_oen) && scl_oen && $past(scl_oen);
  endsequence
  sequence stop_s;
    $rose(sda_oen) && scl_oen && $past(scl_oen);
  endsequence
  sequence take_s(w);
    hsel && hready && htrans[1] && hwrite == w;
  endsequence
  read_wait_a: assert property (take_s(1'b0) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take_s(1'b1) |=> hreadyout)
    else $error("write wait state seen");
  dma_hold_a: assert property (dma_req && !dma_ack |=> dma_req && $stable(dma_addr) && $stable(dma_we))
    else $error("dma request moved");
  dma_drop_a: assert property (dma_req && dma_ack |=> !dma_req)
    else $error("dma request not dropped");
  write_start_a: assert property (events_out.write_began_event |-> ##[1:200] start_s)
    else $error("no start after write");
  read_start_a: assert property (events_out.read_began_event |-> ##[1:200] start_s)
    else $error("no start after read");
  stop_event_a: assert property (stop_s |-> ##[0:60] events_out.stopped_event)
    else $error("no stopped event");
  hold_clock_a: assert property (events_out.suspended_event |=> !scl_oen [*8])
    else $error("clock not held");
endmodule

bind tbm_two_wire_bus_master tbm_checker chk_i (.core_clk, .nrst, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .events_out, .dma_req, .dma_we, .dma_addr, .dma_ack, .scl_oen, .sda_oen);

// ---- testbench/tbm_slave_model.sv ----
/*
  Two-wire slave: acks its address, takes bytes, sends c4, c5, ...
  Assumes a pulled-up data line resolved by the bench.
*/
module tbm_slave_model
  import tbm_pkg::*;
#(
  parameter logic [6:0] ADDR = 7'h53
)
(
  input wire logic scl,
  input wire logic sda,
  output logic slv_oen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 0;
  logic [7:0] tx = 0;
  logic [7:0] rx [0:7];
  logic [3:0] mack = 0;
  logic rd = 0;
  logic on = 0;
  int n = 0;
  int nb = 0;
  initial slv_oen = 1;
  // Start opens a frame, stop closes it
  always @(negedge sda)
    if (scl)
    begin
      on = 1;
      n = 0;
      nb = 0;
      rd = 0;
    end
  always @(posedge sda)
    if (scl) on = 0;
  // Bits in; ninth bit of a read byte is the master's answer
  always @(posedge scl)
    if (on)
    begin
      n = n + 1;
      if (n < 9) sh = {sh[6:0], sda};
      else if (rd)
      begin
        mack = {mack[2:0], sda};
        if (sda) rd = 0; // Not-ack frees the line for stop
      end
    end
  // Drive only while the clock is low
  always @(negedge scl)
    if (on)
    begin
      slv_oen = 1;
      if (n == 8)
      begin
        rx[nb[2:0]] = sh;
        nb = nb + 1;
        if (nb == 1) rd = sh[0] && sh[7:1] == ADDR;
        slv_oen = (nb == 1) ? sh[7:1] != ADDR : rd;
      end
      if (n == 9)
      begin
        n = 0;
        tx = 8'hc3 + 8'(nb);
      end
      if (rd && n < 8) slv_oen = tx[7 - n];
    end
endmodule

// ---- testbench/tb_top.sv ----
/*
  Bench for the two-wire bus master: AHB tasks, DMA memory, slave model.
  Assumes the package offsets and the hand-over timing.
*/
module tb_top
  import tbm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] SLV = 7'h53;
  logic core_clk = 0;
  logic nrst = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic dma_ack = 0;
  logic clr = 0;
  logic scl_q = 1;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] q;
  logic [1:0] htrans = 0;
  logic [7:0] dma_rdata = 0;
  logic [7:0] mem [0:255];
  tbm_tasks_s fabric_tasks = '0;
  tbm_events_s events_out;
  tbm_events_s seen = '0;
  logic hreadyout, hresp, dma_req, dma_we, scl_out, scl_oen, sda_out, sda_oen, slv_oen;
  logic [31:0] hrdata, dma_addr;
  logic [7:0] dma_wdata;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int rise_at = 0;
  int per = 0;
  int rq [3] = '{QTR_SLOW, QTR_MID, QTR_FAST};
  wire logic sda_w = sda_oen & slv_oen; // Pulled-up wired-AND

  tbm_two_wire_bus_master uut (.core_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .fabric_tasks, .events_out, .dma_req, .dma_we,
    .dma_addr, .dma_wdata, .dma_rdata, .dma_ack, .scl_in(scl_oen), .scl_out, .scl_oen, .sda_in(sda_w),
    .sda_out, .sda_oen);
  tbm_slave_model #(.ADDR(SLV)) slv (.scl(scl_oen), .sda(sda_w), .slv_oen);

  initial
  begin
    forever #50 core_clk = ~core_clk;
  end
  // Memory acks next cycle; events stick until cleared; clock period tracked
  always @(posedge core_clk)
  begin
    dma_ack <= dma_req && !dma_ack;
    if (dma_req && !dma_ack && dma_we) mem[dma_addr[7:0]] <= dma_wdata;
    dma_rdata <= dma_req ? mem[dma_addr[7:0]] : ~dma_rdata; // No stale data
    seen <= clr ? '0 : seen | events_out;
    cyc <= cyc + 1;
    scl_q <= scl_oen;
    if (scl_oen && !scl_q)
    begin
      per <= cyc - rise_at;
      rise_at <= cyc;
    end
  end
  // ******************************
  // Tasks
  // ******************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
    checks_done++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    q = hrdata;
  endtask
  // Pulse one task bit and clear seen events; bit 8 only clears
  task automatic trig(input int b);
    fabric_tasks <= tbm_tasks_s'(5'h1 << b);
    clr <= 1;
    @(posedge core_clk);
    fabric_tasks <= '0;
    clr <= 0;
    @(posedge core_clk);
  endtask
  task automatic wait_ev(input int b);
    int t;
    for (t = 0; t < 5000 && seen[b] !== 1'b1; t++) @(posedge core_clk);
    chk(32'(seen[b]), 1, "event");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog: the tests need about 6000 cycles
  initial
  begin
    #4_000_000;
    err_total++;
    complete_run;
  end
  initial
  begin
    foreach (mem[i]) mem[i] = 8'(i * 7 + 3);
    repeat (3) @(posedge core_clk);
    nrst <= 1;
    @(posedge core_clk);
    ahb(0, OFS_BUS_RATE, 0);
    chk(q, 32'(RATE_RST), "rate");
    ahb(0, 12'hffc, 0);
    chk(q, 0, "unmapped");
    ahb(1, OFS_SLAVE_ADDR, 32'h11);
    ahb(1, OFS_ENABLE, 1);
    ahb(1, OFS_WRITE_PTR, 16);
    ahb(1, OFS_WRITE_LEN, 2);
    // Unanswered address at each rate: error, no stop until asked
    foreach (rq[i])
    begin
      ahb(1, OFS_BUS_RATE, i);
      trig(3);
      wait_ev(5);
      chk(32'(per >= 4 * rq[i] && per <= 4 * rq[i] + 3), 1, "period");
      chk(32'(seen[6]), 0, "early stop");
      trig(2);
      wait_ev(6);
      chk({scl_oen, sda_oen}, 2'h3, "idle lines");
    end
    ahb(1, OFS_SLAVE_ADDR, 32'(SLV));
    ahb(0, OFS_SLAVE_ADDR, 0);
    chk(q, 32'(SLV), "address");
    ahb(1, OFS_SHORTCUTS, 1);
    trig(3);
    wait_ev(2);
    ahb(1, OFS_WRITE_PTR, 32'h40);
    wait_ev(6);
    chk(32'(seen[0]), 1, "final write");
    chk(32'(seen[5]), 0, "write error");
    chk(slv.nb, 3, "bytes");
    chk(slv.rx[0], {SLV, 1'b0}, "write addr");
    chk(slv.rx[1], 8'h73, "byte 0");
    chk(slv.rx[2], 8'h7a, "byte 1");
    ahb(1, OFS_READ_PTR, 32);
    ahb(1, OFS_READ_LEN, 3);
    ahb(1, OFS_SHORTCUTS, 2);
    trig(8);
    ahb(1, OFS_BEGIN_READ, 1);
    wait_ev(6);
    chk(32'(seen[1]), 1, "final read");
    chk(slv.rx[0], {SLV, 1'b1}, "read addr");
    chk(slv.mack, 4'h1, "acks");
    for (int i = 0; i < 3; i++) chk(mem[32 + i], 8'hc4 + 8'(i), "stored");
    ahb(0, OFS_READ_AMOUNT, 0);
    chk(q, 3, "amount");
    // Suspend mid-write, refused stop, resume, then idle suspend
    ahb(1, OFS_SHORTCUTS, 0);
    trig(3);
    wait_ev(2);
    trig(1);
    wait_ev(4);
    repeat (100) @(posedge core_clk);
    chk(scl_oen, 0, "held clock");
    trig(2);
    repeat (100) @(posedge core_clk);
    chk(32'(seen[6]), 0, "stop held");
    trig(0);
    trig(2);
    wait_ev(6);
    trig(1);
    repeat (100) @(posedge core_clk);
    chk(32'(seen[4]), 0, "idle suspend");
    trig(2);
    wait_ev(6);
    chk({hresp, scl_out, sda_out}, 0, "fixed outputs");
    ahb(1, OFS_ENABLE, 0);
    ahb(0, OFS_SLAVE_ADDR, 0);
    chk(q, 32'(SLV), "kept address");
    complete_run;
  end
endmodule
